//--- fieldbus_master_model.sv
`timescale 1ns/10ps
`default_nettype none

module fieldbus_master_model (
	input wire logic i_clk,
	output logic o_od_wr,
	output logic o_od_rd,
	output logic [15:0] o_od_index,
	output logic [31:0] o_od_wdata,
	output logic o_sync
);
	initial begin
		o_od_wr = 1'b0;
		o_od_rd = 1'b0;
		o_od_index = 16'h0000;
		o_od_wdata = 32'h0000_0000;
		o_sync = 1'b0;
	end

	// on release the strobes drop and index and data are inverted so a stale value never looks valid
	task automatic access(input logic w, input logic [15:0] idx,
		input logic [31:0] d);
		@(posedge i_clk);
		o_od_wr <= w;
		o_od_rd <= !w;
		o_od_index <= idx;
		o_od_wdata <= d;
		@(posedge i_clk);
		o_od_wr <= 1'b0;
		o_od_rd <= 1'b0;
		o_od_index <= ~idx;
		o_od_wdata <= ~d;
	endtask : access

	// sync pulse n cycles after the previous one
	task automatic sync_gap(input int n);
		repeat (n - 1) @(posedge i_clk);
		o_sync <= 1'b1;
		@(posedge i_clk);
		o_sync <= 1'b0;
	endtask : sync_gap
endmodule : fieldbus_master_model

`default_nettype wire

//--- position_mode_command_logic.sv
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - PP: bit4 rising edge starts move
// - bit5 zero: queue until current move ends
// - bit5 one: abandon current move, start now
// - bit6 selects absolute or relative target
// - status bit8: abnormal stop, motor stopped
// - status bit10: one when target reached
// - status bit12: one when target not acceptable
// - status bit14: a profile parameter is zero
// - status bit15: inverse of bit12
// - immediate start clears status bit12
// - mode 8 selects CSP, shown in display
// - CSP: apply streamed target every sync cycle
// - sync cycle 250 to 4000 us only
// - CSP ignores control word bits 6-4
// - quick stop decel used only option 5
module position_mode_command_logic #(
	parameter int SYNC_BASE_CYCLES = position_mode_pkg::SYNC_BASE_CYC
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_od_wr,
	input wire logic i_od_rd,
	input wire logic [15:0] i_od_index,
	input wire logic [31:0] i_od_wdata,
	output logic [31:0] o_od_rdata,
	output logic o_od_valid,
	output logic o_od_err,
	input wire logic i_sync,
	input wire logic [31:0] i_actual_position,
	input wire logic [31:0] i_actual_velocity,
	input wire logic [15:0] i_error_code,
	input wire logic i_limit_hit,
	input wire logic i_quick_stop,
	input wire logic i_move_done,
	output position_mode_pkg::move_cmd_t o_move,
	output position_mode_pkg::stop_cmd_t o_stop,
	output position_mode_pkg::csp_cmd_t o_csp,
	output logic o_sync_ok
);
	import position_mode_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MOVING = 2'b01,
		ST_QUEUED = 2'b11,
		ST_STOPPED = 2'b10
	} motion_state_t;

	////////////////////////////////////////////////////////////////////////
	// object dictionary storage
	logic [31:0] pulses_per_turn_reg, pulses_per_turn_next;
	logic [15:0] control_word_reg, control_word_next;
	logic [15:0] quick_stop_option_reg, quick_stop_option_next;
	logic [7:0] op_mode_select_reg, op_mode_select_next;
	logic [7:0] op_mode_display_reg, op_mode_display_next;
	logic [31:0] target_position_reg, target_position_next;
	logic [31:0] max_profile_velocity_reg, max_profile_velocity_next;
	logic [31:0] profile_acceleration_reg, profile_acceleration_next;
	logic [31:0] profile_deceleration_reg, profile_deceleration_next;
	logic [31:0] quick_stop_deceleration_reg, quick_stop_deceleration_next;
	logic [31:0] position_offset_reg, position_offset_next;
	logic [31:0] rdata_reg, rdata_next;
	logic valid_reg, valid_next;
	logic err_reg, err_next;

	////////////////////////////////////////////////////////////////////////
	// motion state
	motion_state_t state_reg, state_next;
	logic start_prev_reg, start_prev_next;
	logic [31:0] queued_target_reg, queued_target_next;
	logic abnormal_reg, abnormal_next;
	move_cmd_t move_reg, move_next;
	stop_cmd_t stop_reg, stop_next;
	csp_cmd_t csp_reg, csp_next;

	logic [15:0] status_word;
	logic [31:0] resolved_target;
	logic mode_pp, mode_csp, param_zero, start_edge, stop_cause;

	// index decoding shared by the read and write paths
	function automatic logic is_read_only(input logic [15:0] idx);
		return idx == IDX_LAST_ERROR_CODE || idx == IDX_STATUS_WORD ||
			idx == IDX_OP_MODE_DISPLAY || idx == IDX_ACTUAL_POSITION ||
			idx == IDX_ACTUAL_VELOCITY;
	endfunction : is_read_only

	function automatic logic is_mapped(input logic [15:0] idx);
		return is_read_only(idx) || idx == IDX_PULSES_PER_TURN ||
			idx == IDX_CONTROL_WORD || idx == IDX_QUICK_STOP_OPTION ||
			idx == IDX_OP_MODE_SELECT || idx == IDX_TARGET_POSITION ||
			idx == IDX_MAX_PROFILE_VELOCITY ||
			idx == IDX_PROFILE_ACCELERATION ||
			idx == IDX_PROFILE_DECELERATION ||
			idx == IDX_QUICK_STOP_DECELERATION ||
			idx == IDX_POSITION_OFFSET;
	endfunction : is_mapped

	////////////////////////////////////////////////////////////////////////
	// helpers
	target_resolve u_target_resolve (
		.i_target(target_position_reg),
		.i_base(i_actual_position),
		.i_relative(control_word_reg[CW_RELATIVE_BIT]),
		.o_target(resolved_target)
	);

	sync_cycle_check #(
		.SYNC_BASE_CYCLES(SYNC_BASE_CYCLES)
	) u_sync_cycle_check (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_sync(i_sync),
		.o_sync_ok(o_sync_ok)
	);

	assign mode_pp = op_mode_display_reg == MODE_PROFILE_POSITION;
	assign mode_csp = op_mode_display_reg == MODE_CYCLIC_SYNC_POSITION;
	assign param_zero = max_profile_velocity_reg == '0 ||
		profile_acceleration_reg == '0 ||
		profile_deceleration_reg == '0;
	// csp never looks at the move bits, so no edge is seen there
	assign start_edge = mode_pp && control_word_reg[CW_START_BIT] &&
		!start_prev_reg;
	assign stop_cause = i_limit_hit || i_quick_stop ||
		control_word_reg[CW_HALT_BIT];

	always_comb begin
		status_word = 16'h0000;
		status_word[SW_ABNORMAL_BIT] = abnormal_reg;
		status_word[SW_REACHED_BIT] = state_reg == ST_IDLE ||
			state_reg == ST_STOPPED;
		status_word[SW_BUSY_BIT] = state_reg == ST_QUEUED;
		status_word[SW_PARAM_ZERO_BIT] = param_zero;
		status_word[SW_ACCEPT_BIT] = state_reg != ST_QUEUED;
	end

	////////////////////////////////////////////////////////////////////////
	// object dictionary access
	always_comb begin
		pulses_per_turn_next = pulses_per_turn_reg;
		control_word_next = control_word_reg;
		quick_stop_option_next = quick_stop_option_reg;
		op_mode_select_next = op_mode_select_reg;
		op_mode_display_next = op_mode_display_reg;
		target_position_next = target_position_reg;
		max_profile_velocity_next = max_profile_velocity_reg;
		profile_acceleration_next = profile_acceleration_reg;
		profile_deceleration_next = profile_deceleration_reg;
		quick_stop_deceleration_next = quick_stop_deceleration_reg;
		position_offset_next = position_offset_reg;
		rdata_next = rdata_reg;
		valid_next = i_od_wr || i_od_rd;
		err_next = 1'b0;
		if (i_od_wr) begin
			err_next = !is_mapped(i_od_index) || is_read_only(i_od_index);
			case (i_od_index)
				IDX_PULSES_PER_TURN: begin
					pulses_per_turn_next = i_od_wdata;
				end
				IDX_CONTROL_WORD: begin
					control_word_next = i_od_wdata[15:0];
				end
				IDX_QUICK_STOP_OPTION: begin
					quick_stop_option_next = i_od_wdata[15:0];
				end
				IDX_OP_MODE_SELECT: begin
					op_mode_select_next = i_od_wdata[7:0];
				end
				IDX_TARGET_POSITION: begin
					target_position_next = i_od_wdata;
				end
				IDX_MAX_PROFILE_VELOCITY: begin
					max_profile_velocity_next = i_od_wdata;
				end
				IDX_PROFILE_ACCELERATION: begin
					profile_acceleration_next = i_od_wdata;
				end
				IDX_PROFILE_DECELERATION: begin
					profile_deceleration_next = i_od_wdata;
				end
				IDX_QUICK_STOP_DECELERATION: begin
					quick_stop_deceleration_next = i_od_wdata;
				end
				IDX_POSITION_OFFSET: begin
					position_offset_next = i_od_wdata;
				end
				default: begin
				end
			endcase
		end else if (i_od_rd) begin
			err_next = !is_mapped(i_od_index);
			case (i_od_index)
				IDX_PULSES_PER_TURN: rdata_next = pulses_per_turn_reg;
				IDX_LAST_ERROR_CODE: rdata_next = {16'h0000, i_error_code};
				IDX_CONTROL_WORD: rdata_next = {16'h0000, control_word_reg};
				IDX_STATUS_WORD: rdata_next = {16'h0000, status_word};
				IDX_QUICK_STOP_OPTION: begin
					rdata_next = {16'h0000, quick_stop_option_reg};
				end
				IDX_OP_MODE_SELECT: rdata_next = {24'h00_0000, op_mode_select_reg};
				IDX_OP_MODE_DISPLAY: begin
					rdata_next = {24'h00_0000, op_mode_display_reg};
				end
				IDX_ACTUAL_POSITION: rdata_next = i_actual_position;
				IDX_ACTUAL_VELOCITY: rdata_next = i_actual_velocity;
				IDX_TARGET_POSITION: rdata_next = target_position_reg;
				IDX_MAX_PROFILE_VELOCITY: rdata_next = max_profile_velocity_reg;
				IDX_PROFILE_ACCELERATION: rdata_next = profile_acceleration_reg;
				IDX_PROFILE_DECELERATION: rdata_next = profile_deceleration_reg;
				IDX_QUICK_STOP_DECELERATION: begin
					rdata_next = quick_stop_deceleration_reg;
				end
				IDX_POSITION_OFFSET: rdata_next = position_offset_reg;
				default: rdata_next = 32'h0000_0000;
			endcase
		end
		// unsupported mode codes leave the running mode untouched
		if (op_mode_select_reg == MODE_PROFILE_POSITION ||
			op_mode_select_reg == MODE_CYCLIC_SYNC_POSITION) begin
			op_mode_display_next = op_mode_select_reg;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pulses_per_turn_reg <= RST_WORD32;
			control_word_reg <= RST_WORD16;
			quick_stop_option_reg <= RST_WORD16;
			op_mode_select_reg <= RST_MODE;
			op_mode_display_reg <= RST_MODE;
			target_position_reg <= RST_WORD32;
			max_profile_velocity_reg <= RST_WORD32;
			profile_acceleration_reg <= RST_WORD32;
			profile_deceleration_reg <= RST_WORD32;
			quick_stop_deceleration_reg <= RST_WORD32;
			position_offset_reg <= RST_WORD32;
			rdata_reg <= RST_WORD32;
			valid_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			pulses_per_turn_reg <= pulses_per_turn_next;
			control_word_reg <= control_word_next;
			quick_stop_option_reg <= quick_stop_option_next;
			op_mode_select_reg <= op_mode_select_next;
			op_mode_display_reg <= op_mode_display_next;
			target_position_reg <= target_position_next;
			max_profile_velocity_reg <= max_profile_velocity_next;
			profile_acceleration_reg <= profile_acceleration_next;
			profile_deceleration_reg <= profile_deceleration_next;
			quick_stop_deceleration_reg <= quick_stop_deceleration_next;
			position_offset_reg <= position_offset_next;
			rdata_reg <= rdata_next;
			valid_reg <= valid_next;
			err_reg <= err_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// move sequencing
	always_comb begin
		state_next = state_reg;
		start_prev_next = control_word_reg[CW_START_BIT];
		queued_target_next = queued_target_reg;
		abnormal_next = abnormal_reg;
		move_next = move_reg;
		move_next.start = 1'b0;
		move_next.abort = 1'b0;
		move_next.velocity = max_profile_velocity_reg;
		move_next.accel = profile_acceleration_reg;
		move_next.decel = profile_deceleration_reg;
		stop_next.stop = 1'b0;
		// zero decel means stop at the drive's hardest rate
		stop_next.decel = (quick_stop_option_reg == QS_OPTION_ENABLE) ?
			quick_stop_deceleration_reg : 32'h0000_0000;
		csp_next.valid = 1'b0;
		csp_next.target = csp_reg.target;
		if (mode_csp && i_sync) begin
			csp_next.valid = 1'b1;
			csp_next.target = target_position_reg + position_offset_reg;
		end
		if (stop_cause) begin
			// a stop cause outranks any start in the same cycle
			abnormal_next = 1'b1;
			stop_next.stop = state_reg != ST_STOPPED;
			state_next = ST_STOPPED;
		end else begin
			case (state_reg)
				ST_IDLE, ST_STOPPED: begin
					if (start_edge && !param_zero) begin
						move_next.start = 1'b1;
						move_next.target = resolved_target;
						abnormal_next = 1'b0;
						state_next = ST_MOVING;
					end
				end
				ST_MOVING: begin
					if (start_edge && !param_zero &&
						control_word_reg[CW_IMMEDIATE_BIT]) begin
						move_next.abort = 1'b1;
						move_next.start = 1'b1;
						move_next.target = resolved_target;
					end else if (start_edge && !param_zero) begin
						queued_target_next = resolved_target;
						state_next = ST_QUEUED;
					end else if (i_move_done) begin
						state_next = ST_IDLE;
					end
				end
				ST_QUEUED: begin
					if (start_edge && !param_zero &&
						control_word_reg[CW_IMMEDIATE_BIT]) begin
						// drops the held move and frees the busy flag
						move_next.abort = 1'b1;
						move_next.start = 1'b1;
						move_next.target = resolved_target;
						state_next = ST_MOVING;
					end else if (i_move_done) begin
						move_next.start = 1'b1;
						move_next.target = queued_target_reg;
						state_next = ST_MOVING;
					end
				end
				default: begin
					state_next = ST_IDLE;
				end
			endcase
		end
		// leaving pp drops held and pending moves, but a stop still latches
		if (!mode_pp) begin
			move_next.start = 1'b0;
			move_next.abort = 1'b0;
			move_next.target = move_reg.target;
			if (state_next != ST_STOPPED) begin
				state_next = ST_IDLE;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_reg <= ST_IDLE;
			start_prev_reg <= 1'b0;
			queued_target_reg <= RST_WORD32;
			abnormal_reg <= 1'b0;
			move_reg <= '0;
			stop_reg <= '0;
			csp_reg <= '0;
		end else begin
			state_reg <= state_next;
			start_prev_reg <= start_prev_next;
			queued_target_reg <= queued_target_next;
			abnormal_reg <= abnormal_next;
			move_reg <= move_next;
			stop_reg <= stop_next;
			csp_reg <= csp_next;
		end
	end

	assign o_od_rdata = rdata_reg;
	assign o_od_valid = valid_reg;
	assign o_od_err = err_reg;
	assign o_move = move_reg;
	assign o_stop = stop_reg;
	assign o_csp = csp_reg;

endmodule : position_mode_command_logic

`default_nettype wire

//--- position_mode_command_logic_props.sv
`timescale 1ns/10ps
`default_nettype none

module position_mode_command_logic_props #(
	parameter int SYNC_BASE_CYCLES = position_mode_pkg::SYNC_BASE_CYC
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_od_wr,
	input wire logic i_od_rd,
	input wire logic [15:0] i_od_index,
	input wire logic [31:0] o_od_rdata,
	input wire logic o_od_valid,
	input wire logic o_od_err,
	input wire logic i_sync,
	input wire position_mode_pkg::move_cmd_t o_move,
	input wire position_mode_pkg::stop_cmd_t o_stop,
	input wire position_mode_pkg::csp_cmd_t o_csp,
	input wire logic o_sync_ok
);
	import position_mode_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	////////////////////////////////
	property p_od_answer;
		o_od_valid == $past(i_od_wr || i_od_rd);
	endproperty
	a_od_answer: assert property (p_od_answer)
		else $error("object answer not one cycle after strobe");
	// a read of the status word must show bit15 as the inverse of bit12
	property p_status_sense;
		o_od_valid && !o_od_err &&
		$past(i_od_rd && !i_od_wr && i_od_index == IDX_STATUS_WORD)
		|-> o_od_rdata[SW_ACCEPT_BIT] != o_od_rdata[SW_BUSY_BIT];
	endproperty
	a_status_sense: assert property (p_status_sense)
		else $error("status accept bit not inverse of busy bit");
	property p_start_pulse;
		o_move.start |=> !o_move.start;
	endproperty
	a_start_pulse: assert property (p_start_pulse)
		else $error("start held longer than one cycle");
	property p_abort_pair;
		o_move.abort |-> o_move.start;
	endproperty
	a_abort_pair: assert property (p_abort_pair)
		else $error("abort without a new start");
	property p_target_hold;
		!o_move.start |-> $stable(o_move.target);
	endproperty
	a_target_hold: assert property (p_target_hold)
		else $error("move target changed without a start");
	property p_stop_wins;
		o_stop.stop |-> !o_move.start;
	endproperty
	a_stop_wins: assert property (p_stop_wins)
		else $error("start issued together with a stop");
	property p_csp_sync;
		o_csp.valid |-> $past(i_sync);
	endproperty
	a_csp_sync: assert property (p_csp_sync)
		else $error("streamed target without a sync");
	property p_csp_no_move;
		o_csp.valid |-> !o_move.start;
	endproperty
	a_csp_no_move: assert property (p_csp_no_move)
		else $error("move start while streaming");
	// the sync verdict may only move right after a sync event
	property p_sync_ok_hold;
		!$past(i_sync) |-> $stable(o_sync_ok);
	endproperty
	a_sync_ok_hold: assert property (p_sync_ok_hold)
		else $error("sync verdict changed between syncs");

	c_abort: cover property (o_move.abort);
	c_stop: cover property (o_stop.stop);
	c_csp: cover property (o_csp.valid);
	c_start: cover property (o_move.start);
endmodule : position_mode_command_logic_props

bind position_mode_command_logic position_mode_command_logic_props #(
	.SYNC_BASE_CYCLES(SYNC_BASE_CYCLES)
) props_i (.i_clk, .i_sys_rst, .i_od_wr, .i_od_rd, .i_od_index, .o_od_rdata,
	.o_od_valid, .o_od_err, .i_sync, .o_move, .o_stop, .o_csp, .o_sync_ok);

`default_nettype wire

//--- position_mode_pkg.sv
package position_mode_pkg;

	////////////////////////////////////////////////////////////////////////
	// object dictionary indices
	localparam logic [15:0] IDX_PULSES_PER_TURN = 16'h2000;
	localparam logic [15:0] IDX_LAST_ERROR_CODE = 16'h603f;
	localparam logic [15:0] IDX_CONTROL_WORD = 16'h6040;
	localparam logic [15:0] IDX_STATUS_WORD = 16'h6041;
	localparam logic [15:0] IDX_QUICK_STOP_OPTION = 16'h605a;
	localparam logic [15:0] IDX_OP_MODE_SELECT = 16'h6060;
	localparam logic [15:0] IDX_OP_MODE_DISPLAY = 16'h6061;
	localparam logic [15:0] IDX_ACTUAL_POSITION = 16'h6064;
	localparam logic [15:0] IDX_ACTUAL_VELOCITY = 16'h606c;
	localparam logic [15:0] IDX_TARGET_POSITION = 16'h607a;
	localparam logic [15:0] IDX_MAX_PROFILE_VELOCITY = 16'h6081;
	localparam logic [15:0] IDX_PROFILE_ACCELERATION = 16'h6083;
	localparam logic [15:0] IDX_PROFILE_DECELERATION = 16'h6084;
	localparam logic [15:0] IDX_QUICK_STOP_DECELERATION = 16'h6085;
	localparam logic [15:0] IDX_POSITION_OFFSET = 16'h60b0;

	////////////////////////////////////////////////////////////////////////
	// values after reset
	localparam logic [31:0] RST_WORD32 = 32'h0000_0000;
	localparam logic [15:0] RST_WORD16 = 16'h0000;
	localparam logic [7:0] RST_MODE = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// modes and option codes
	localparam logic [7:0] MODE_PROFILE_POSITION = 8'h01;
	localparam logic [7:0] MODE_CYCLIC_SYNC_POSITION = 8'h08;
	localparam logic [15:0] QS_OPTION_ENABLE = 16'h0005;

	////////////////////////////////////////////////////////////////////////
	// control word and status word bit positions
	localparam int CW_START_BIT = 4;
	localparam int CW_IMMEDIATE_BIT = 5;
	localparam int CW_RELATIVE_BIT = 6;
	localparam int CW_HALT_BIT = 8;
	localparam int SW_ABNORMAL_BIT = 8;
	localparam int SW_REACHED_BIT = 10;
	localparam int SW_BUSY_BIT = 12;
	localparam int SW_PARAM_ZERO_BIT = 14;
	localparam int SW_ACCEPT_BIT = 15;

	////////////////////////////////////////////////////////////////////////
	// sync cycle timing
	localparam int CLK_MHZ = 200;
	localparam int SYNC_BASE_US = 250;
	localparam int SYNC_BASE_CYC = SYNC_BASE_US * CLK_MHZ;
	localparam int SYNC_NUM_PERIODS = 6;
	localparam int SYNC_MULT [SYNC_NUM_PERIODS] = '{1, 2, 3, 4, 8, 16};
	localparam int SYNC_TOL_CYC = 4;
	localparam int SYNC_CNT_W = 21;

	////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic start;
		logic abort;
		logic [31:0] target;
		logic [31:0] velocity;
		logic [31:0] accel;
		logic [31:0] decel;
	} move_cmd_t;

	typedef struct packed {
		logic stop;
		logic [31:0] decel;
	} stop_cmd_t;

	typedef struct packed {
		logic valid;
		logic [31:0] target;
	} csp_cmd_t;

endpackage : position_mode_pkg

//--- sync_cycle_check.sv
`timescale 1ns/10ps
`default_nettype none

module sync_cycle_check #(
	parameter int SYNC_BASE_CYCLES = position_mode_pkg::SYNC_BASE_CYC
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_sync,
	output logic o_sync_ok
);
	import position_mode_pkg::*;

	logic [SYNC_CNT_W-1:0] count_reg, count_next;
	logic ok_reg, ok_next;

	// true when the interval is one of the legal sync periods
	function automatic logic legal_period(input logic [SYNC_CNT_W-1:0] n);
		logic hit;
		int lo;
		int hi;
		hit = 1'b0;
		for (int k = 0; k < SYNC_NUM_PERIODS; k++) begin
			lo = SYNC_MULT[k] * SYNC_BASE_CYCLES - SYNC_TOL_CYC;
			hi = SYNC_MULT[k] * SYNC_BASE_CYCLES + SYNC_TOL_CYC;
			if (int'(n) >= lo && int'(n) <= hi) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : legal_period

	always_comb begin
		count_next = count_reg;
		ok_next = ok_reg;
		if (i_sync) begin
			ok_next = legal_period(count_reg);
			count_next = SYNC_CNT_W'(1);
		end else if (count_reg != {SYNC_CNT_W{1'b1}}) begin
			// saturate so a lost master never wraps into a legal period
			count_next = count_reg + SYNC_CNT_W'(1);
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			count_reg <= '0;
			ok_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			ok_reg <= ok_next;
		end
	end

	assign o_sync_ok = ok_reg;

endmodule : sync_cycle_check

`default_nettype wire

//--- target_resolve.sv
`timescale 1ns/10ps
`default_nettype none

module target_resolve (
	input wire logic [31:0] i_target,
	input wire logic [31:0] i_base,
	input wire logic i_relative,
	output logic [31:0] o_target
);
	// relative targets add to the position at the moment of acceptance
	always_comb begin
		if (i_relative) begin
			o_target = i_base + i_target;
		end else begin
			o_target = i_target;
		end
	end

endmodule : target_resolve

`default_nettype wire

//--- test_position_mode_command_logic.sv
`timescale 1ns/10ps
`default_nettype none

module test_position_mode_command_logic;
	import position_mode_pkg::*;
	localparam int BASE = 100;
	localparam int LIMIT = 20000;
	logic i_clk, i_sys_rst, i_od_wr, i_od_rd, i_sync, o_od_valid, o_od_err;
	logic o_sync_ok, i_limit_hit, i_quick_stop, i_move_done;
	logic [15:0] i_od_index, i_error_code;
	logic [31:0] i_od_wdata, o_od_rdata, i_actual_position, i_actual_velocity;
	logic [31:0] tgt, ofs;
	logic [33:0] e;
	logic [33:0] od_q[$];
	logic [33:0] csp_q[$];
	logic [32:0] mv_q[$];
	move_cmd_t o_move;
	stop_cmd_t o_stop;
	csp_cmd_t o_csp;
	int failures, n_compared, cyc, n_stop;
	int gaps[5] = '{BASE, 250, 2 * BASE, BASE + 5, 3 * BASE + 4};
	logic oks[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

	position_mode_command_logic #(.SYNC_BASE_CYCLES(BASE))
	position_mode_command_logic_i (.i_clk, .i_sys_rst, .i_od_wr, .i_od_rd,
		.i_od_index, .i_od_wdata, .o_od_rdata, .o_od_valid, .o_od_err, .i_sync,
		.i_actual_position, .i_actual_velocity, .i_error_code, .i_limit_hit,
		.i_quick_stop, .i_move_done, .o_move, .o_stop, .o_csp, .o_sync_ok);
	fieldbus_master_model fieldbus_master_model_i (.i_clk, .o_od_wr(i_od_wr),
		.o_od_rd(i_od_rd), .o_od_index(i_od_index), .o_od_wdata(i_od_wdata),
		.o_sync(i_sync));

	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	////////////////////////////////
	task automatic tally_and_finish;
		if (failures == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic cmp(input string what, input logic [33:0] exp,
		input logic [33:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic idle(input int n);
		repeat (n) @(posedge i_clk);
	endtask : idle

	task automatic wr(input logic [15:0] idx, input logic [31:0] d,
		input logic err = 1'b0);
		od_q.push_back({1'b0, err, 32'h0000_0000});
		fieldbus_master_model_i.access(1'b1, idx, d);
	endtask : wr

	task automatic rd(input logic [15:0] idx, input logic [31:0] exp,
		input logic err = 1'b0);
		od_q.push_back({1'b1, err, exp});
		fieldbus_master_model_i.access(1'b0, idx, 32'h0000_0000);
	endtask : rd

	// target, then a low-to-high step of the start bit
	task automatic mv(input logic [31:0] t, input logic [15:0] cw,
		input logic go, input logic [31:0] exp);
		if (go) begin
			mv_q.push_back({cw[CW_IMMEDIATE_BIT], exp});
		end
		wr(IDX_TARGET_POSITION, t);
		wr(IDX_CONTROL_WORD, {16'h0000, cw & 16'hffef});
		wr(IDX_CONTROL_WORD, {16'h0000, cw});
		idle(4);
	endtask : mv

	////////////////////////////////
	// results are judged when they appear, oldest note first
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			failures++;
			$display("mismatch timeout expected %0d seen %0d", LIMIT - 1, cyc);
			tally_and_finish();
		end
		if (!i_sys_rst && o_od_valid === 1'b1) begin
			e = od_q.size() ? od_q.pop_front() : '1;
			cmp("od_answer", e, {e[33], o_od_err, e[33] ? o_od_rdata : 32'h0});
		end
		if (!i_sys_rst && o_move.start === 1'b1) begin
			e = {1'b0, mv_q.size() ? mv_q.pop_front() : 33'h1_xxxx_xxxx};
			cmp("move", e, {1'b0, o_move.abort, o_move.target});
			cmp("move_vel", 34'h0_0000_0100, {2'b00, o_move.velocity});
		end
		if (!i_sys_rst && o_stop.stop === 1'b1) begin
			n_stop++;
		end
		if (!i_sys_rst && o_csp.valid === 1'b1) begin
			e = csp_q.size() ? csp_q.pop_front() : 'x;
			cmp("csp", e, {e[33], e[33] ? o_sync_ok : e[32], o_csp.target});
		end
	end

	initial begin
		tgt = $urandom(32'h0000_170b);
		i_sys_rst = 1'b1;
		i_limit_hit = 1'b0;
		i_quick_stop = 1'b0;
		i_move_done = 1'b0;
		i_actual_position = 32'h0000_0000;
		i_actual_velocity = $urandom;
		i_error_code = 16'($urandom);
		repeat (3) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		rd(IDX_STATUS_WORD, 32'h0000_c400);
		rd(16'h1234, 32'h0000_0000, 1'b1);
		wr(IDX_STATUS_WORD, 32'h0000_0000, 1'b1);
		rd(IDX_LAST_ERROR_CODE, {16'h0000, i_error_code});
		rd(IDX_ACTUAL_VELOCITY, i_actual_velocity);
		wr(IDX_MAX_PROFILE_VELOCITY, 32'h0000_0100);
		wr(IDX_PROFILE_ACCELERATION, 32'h0000_0080);
		rd(IDX_STATUS_WORD, 32'h0000_c400);
		wr(IDX_PROFILE_DECELERATION, 32'h0000_0040);
		wr(IDX_OP_MODE_SELECT, {24'h00_0000, MODE_PROFILE_POSITION});
		idle(2);
		rd(IDX_OP_MODE_DISPLAY, 32'h0000_0001);
		rd(IDX_STATUS_WORD, 32'h0000_8400);
		mv(tgt, 16'h001f, 1'b1, tgt);
		rd(IDX_STATUS_WORD, 32'h0000_8000);
		mv(tgt + 1, 16'h001f, 1'b0, 0);
		rd(IDX_STATUS_WORD, 32'h0000_1000);
		mv_q.push_back({1'b0, tgt + 1});
		i_move_done <= 1'b1;
		idle(1);
		i_move_done <= 1'b0;
		idle(3);
		rd(IDX_STATUS_WORD, 32'h0000_8000);
		mv(tgt + 2, 16'h001f, 1'b0, 0);
		mv(tgt + 3, 16'h003f, 1'b1, tgt + 3);
		rd(IDX_STATUS_WORD, 32'h0000_8000);
		i_move_done <= 1'b1;
		idle(1);
		i_move_done <= 1'b0;
		idle(3);
		rd(IDX_STATUS_WORD, 32'h0000_8400);
		i_actual_position <= $urandom;
		idle(1);
		rd(IDX_ACTUAL_POSITION, i_actual_position);
		mv(tgt, 16'h005f, 1'b1, i_actual_position + tgt);
		i_limit_hit <= 1'b1;
		idle(1);
		i_limit_hit <= 1'b0;
		idle(3);
		rd(IDX_STATUS_WORD, 32'h0000_8500);
		mv(tgt, 16'h001f, 1'b1, tgt);
		rd(IDX_STATUS_WORD, 32'h0000_8000);
		i_quick_stop <= 1'b1;
		idle(1);
		i_quick_stop <= 1'b0;
		idle(3);
		rd(IDX_STATUS_WORD, 32'h0000_8500);
		wr(IDX_QUICK_STOP_DECELERATION, 32'h0000_0777);
		wr(IDX_QUICK_STOP_OPTION, {16'h0000, QS_OPTION_ENABLE});
		idle(3);
		cmp("stop_decel", 34'h0_0000_0777, {2'b00, o_stop.decel});
		wr(IDX_QUICK_STOP_OPTION, 32'h0000_0004);
		idle(3);
		cmp("stop_decel", 34'h0_0000_0000, {2'b00, o_stop.decel});
		ofs = $urandom;
		wr(IDX_POSITION_OFFSET, ofs);
		wr(IDX_OP_MODE_SELECT, {24'h00_0000, MODE_CYCLIC_SYNC_POSITION});
		idle(2);
		rd(IDX_OP_MODE_DISPLAY, 32'h0000_0008);
		mv(tgt, 16'h005f, 1'b0, 0);
		csp_q.push_back({2'b00, tgt + ofs});
		fieldbus_master_model_i.sync_gap(BASE);
		for (int k = 0; k < 5; k++) begin
			csp_q.push_back({1'b1, oks[k], tgt + ofs});
			fieldbus_master_model_i.sync_gap(gaps[k]);
		end
		idle(4);
		cmp("stop_count", 34'h0_0000_0002, 34'(n_stop));
		cmp("notes_left", 34'h0_0000_0000,
			34'(od_q.size() + mv_q.size() + csp_q.size()));
		tally_and_finish();
	end
endmodule : test_position_mode_command_logic

`default_nettype wire
